//--- inc/io_space_consts.svh
// io space address map, field positions, reset values and timing in nanoseconds
`ifndef IO_SPACE_CONSTS_SVH
`define IO_SPACE_CONSTS_SVH

`define IO_LAST_ADDR 8'h3f
`define IO_BIT_LAST_ADDR 8'h1f
`define IO_DATA_OFFSET 8'h20
`define IO_DATA_LAST_ADDR 8'h5f
`define IO_SCRATCH_BASE 8'h13
`define IO_SCRATCH_COUNT 3
`define IO_FLAG_ADDR 8'h16
`define IO_NVM_CTRL_ADDR 8'h17
`define NVM_CTRL_START_BIT 0
`define NVM_CTRL_BUSY_BIT 1
`define SCRATCH_RESET 8'h00
`define FLAG_RESET 8'h00
`define NVM_WRITE_TIME_NS 3400
`define CLK_PERIOD_NS 8

`endif

//--- inc/io_space_pkg.sv
// types for the cpu-facing io space access port
`default_nettype none
package io_space_pkg;
   typedef enum logic [2:0] {
      OP_IN,
      OP_OUT,
      OP_LOAD,
      OP_STORE,
      OP_SET_BIT,
      OP_CLEAR_BIT,
      OP_SKIP_IF_SET,
      OP_SKIP_IF_CLEAR
   } io_op_t;

   // one access from the cpu core, addr is io or data address by op
   typedef struct packed {
      logic valid;
      io_op_t op;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } io_req_t;

   // answer one cycle after the request
   typedef struct packed {
      logic done;
      logic [7:0] rdata;
      logic skip;
      logic err;
   } io_rsp_t;
endpackage : io_space_pkg
`default_nettype wire

//--- rtl/nvm_write_keeper.sv
// non-volatile write timer that keeps running through a system reset
`include "io_space_consts.svh"
`default_nettype none
module nvm_write_keeper #(
   parameter int unsigned WRITE_CYCLES = (`NVM_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic por_n_i,
   input wire logic start_i,
   output logic busy_o,
   output logic done_o
);
   localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic busy_d;
   logic done_d;

   ////////////////////////////////////////////////////////////////////////
   // only power-on clears the timer; system reset never reaches it
   assign busy_d = busy_o ? (count_q != CW'(1)) : start_i;
   assign count_d = busy_o ? count_q - CW'(1) : (start_i ? CW'(WRITE_CYCLES) : count_q);
   assign done_d = busy_o && (count_q == CW'(1));

   always_ff @(posedge clk_i) begin
      if (!por_n_i) begin
         count_q <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         count_q <= count_d;
         busy_o <= busy_d;
         done_o <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // a running write ends only by its own count
   a_write_runs_on: assert property (@(posedge clk_i) disable iff (!por_n_i)
      busy_o && count_q != CW'(1) |=> busy_o)
      else $error("nvm write stopped early");
   a_write_length: assert property (@(posedge clk_i) disable iff (!por_n_i)
      !busy_o && start_i |=> busy_o && count_q == CW'(WRITE_CYCLES))
      else $error("nvm write not loaded with full length");
endmodule : nvm_write_keeper
`default_nettype wire

//--- rtl/io_space_scratch_regs.sv
// io space decode with scratch, flag and nvm control registers
`include "io_space_consts.svh"
`default_nettype none
module io_space_scratch_regs #(
   parameter int unsigned SCRATCH_COUNT = `IO_SCRATCH_COUNT,
   parameter int unsigned NVM_WRITE_TIME_NS = `NVM_WRITE_TIME_NS
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic por_n_i,
   input wire io_space_pkg::io_req_t req_i,
   input wire logic [7:0] flag_event_i,
   output io_space_pkg::io_rsp_t rsp_o,
   output logic [7:0] flag_o,
   output logic nvm_write_o,
   output logic nvm_busy_o
);
   import io_space_pkg::*;

   // least time rounds up to whole cycles
   localparam int unsigned NVM_WRITE_CYCLES =
      (NVM_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   logic [7:0] scratch_q [SCRATCH_COUNT];
   logic [7:0] scratch_d [SCRATCH_COUNT];
   logic [7:0] flag_d;
   logic nvm_busy;
   io_rsp_t rsp_d;

   ////////////////////////////////////////////////////////////////////////
   // operation class decode
   wire is_port_op = req_i.op == OP_IN || req_i.op == OP_OUT;
   wire is_data_op = req_i.op == OP_LOAD || req_i.op == OP_STORE;
   wire is_bit_wr = req_i.op == OP_SET_BIT || req_i.op == OP_CLEAR_BIT;
   wire is_bit_test = req_i.op == OP_SKIP_IF_SET || req_i.op == OP_SKIP_IF_CLEAR;
   wire is_full_wr = req_i.op == OP_OUT || req_i.op == OP_STORE;

   ////////////////////////////////////////////////////////////////////////
   // address translation and range checks
   wire data_in_io = req_i.addr >= `IO_DATA_OFFSET && req_i.addr <= `IO_DATA_LAST_ADDR;
   wire [7:0] io_addr = is_data_op ? req_i.addr - `IO_DATA_OFFSET : req_i.addr;
   wire addr_ok = is_data_op ? data_in_io :
      (is_port_op ? req_i.addr <= `IO_LAST_ADDR :
       req_i.addr <= `IO_BIT_LAST_ADDR);
   wire acc = req_i.valid && addr_ok;
   wire wr = acc && (is_full_wr || is_bit_wr);

   ////////////////////////////////////////////////////////////////////////
   // write mask and value; bit ops carry a one-hot mask only
   wire [7:0] bit_hot = 8'h01 << req_i.bit_sel;
   wire [7:0] wr_mask = is_bit_wr ? bit_hot : 8'hff;
   wire [7:0] wr_val = req_i.op == OP_SET_BIT ? 8'hff :
      (req_i.op == OP_CLEAR_BIT ? 8'h00 : req_i.wdata);
   wire [7:0] wr_ones = wr_mask & wr_val;

   ////////////////////////////////////////////////////////////////////////
   // register hits
   wire scr_hit = io_addr >= `IO_SCRATCH_BASE &&
      io_addr < `IO_SCRATCH_BASE + 8'(SCRATCH_COUNT);
   wire [7:0] scr_idx = io_addr - `IO_SCRATCH_BASE;
   wire flag_hit = io_addr == `IO_FLAG_ADDR;
   wire nvm_hit = io_addr == `IO_NVM_CTRL_ADDR;

   // scratch storage, one entry per register
   for (genvar i = 0; i < SCRATCH_COUNT; i++) begin : g_scratch
      wire hit = wr && scr_hit && scr_idx == 8'(i);
      assign scratch_d[i] = hit ? (scratch_q[i] & ~wr_mask) | wr_ones : scratch_q[i];
      always_ff @(posedge clk_i) begin
         if (!reset_n_i) begin
            scratch_q[i] <= `SCRATCH_RESET;
         end else begin
            scratch_q[i] <= scratch_d[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags: ones clear, zeros keep, a new event wins over the clear
   wire [7:0] flag_clr = (wr && flag_hit) ? wr_ones : 8'h00;
   assign flag_d = (flag_o & ~flag_clr) | flag_event_i;

   // nvm start only when idle; a second start while busy is dropped
   wire nvm_start = wr && nvm_hit && wr_ones[`NVM_CTRL_START_BIT] && !nvm_busy;

   ////////////////////////////////////////////////////////////////////////
   // read data mux; reserved locations read as zero
   wire [7:0] scr_rd = scr_hit ? scratch_q[scr_idx[1:0]] : 8'h00;
   wire [7:0] nvm_rd = 8'(nvm_busy) << `NVM_CTRL_BUSY_BIT;
   wire [7:0] rd_val = scr_hit ? scr_rd : (flag_hit ? flag_o : (nvm_hit ? nvm_rd : 8'h00));
   wire bit_val = rd_val[req_i.bit_sel];
   wire skip_d = acc && is_bit_test &&
      (req_i.op == OP_SKIP_IF_SET ? bit_val : !bit_val);

   always_comb begin
      rsp_d.done = req_i.valid;
      rsp_d.rdata = (acc && (req_i.op == OP_IN || req_i.op == OP_LOAD)) ? rd_val : 8'h00;
      rsp_d.skip = skip_d;
      rsp_d.err = req_i.valid && !addr_ok;
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rsp_o <= '0;
         flag_o <= `FLAG_RESET;
      end else begin
         rsp_o <= rsp_d;
         flag_o <= flag_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!por_n_i) begin
         nvm_write_o <= 1'b0;
         nvm_busy_o <= 1'b0;
      end else begin
         nvm_write_o <= nvm_start;
         nvm_busy_o <= nvm_busy;
      end
   end

   // write timer sits outside the system reset
   nvm_write_keeper #(
      .WRITE_CYCLES(NVM_WRITE_CYCLES)
   ) u_nvm_keeper (
      .clk_i(clk_i),
      .por_n_i(por_n_i),
      .start_i(nvm_start),
      .busy_o(nvm_busy),
      .done_o()
   );

   ////////////////////////////////////////////////////////////////////////
   // checks: named steps of a store then a read back, and of an nvm start
   sequence s_store_scratch0;
      req_i.valid && req_i.op == OP_STORE &&
         req_i.addr == `IO_SCRATCH_BASE + `IO_DATA_OFFSET;
   endsequence

   sequence s_read_back;
      req_i.valid && req_i.op == OP_IN && req_i.addr == `IO_SCRATCH_BASE;
   endsequence

   // a full write of one to the start bit of the nvm control register
   sequence s_nvm_kick;
      acc && is_full_wr && nvm_hit && req_i.wdata[`NVM_CTRL_START_BIT];
   endsequence

   // data path: stores land, reads return them, one-cycle answers
   a_store_readback: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      s_store_scratch0 ##1 s_read_back |=> rsp_o.rdata == $past(req_i.wdata, 2))
      else $error("scratch did not return last store");
   a_data_offset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      s_store_scratch0 |=> scratch_q[0] == $past(req_i.wdata))
      else $error("data space store missed io register");
   a_one_cycle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      req_i.valid |=> rsp_o.done ##1 (rsp_o.done == $past(req_i.valid)))
      else $error("access not answered in one cycle");

   // address windows per instruction family; a refused access reads zero
   a_bit_range_err: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      req_i.valid && (is_bit_wr || is_bit_test) && req_i.addr > `IO_BIT_LAST_ADDR
      |=> rsp_o.err && !rsp_o.skip)
      else $error("bit op beyond bit range accepted");
   a_port_window: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      req_i.valid && is_port_op |=> rsp_o.err == ($past(req_i.addr) > `IO_LAST_ADDR))
      else $error("port op window wrong");
   a_load_window: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      req_i.valid && is_data_op |=> rsp_o.err == !$past(data_in_io))
      else $error("data space window wrong");
   a_refused_reads_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      req_i.valid && !addr_ok |=> rsp_o.rdata == 8'h00)
      else $error("refused access returned data");

   // bit operations touch and test exactly one bit
   a_bit_only: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      req_i.valid && is_bit_wr && req_i.addr == `IO_SCRATCH_BASE
      |=> (scratch_q[0] & ~$past(bit_hot)) == ($past(scratch_q[0]) & ~$past(bit_hot)))
      else $error("bit op changed other bits");
   a_skip_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      acc && req_i.op == OP_SKIP_IF_SET |=> rsp_o.skip == $past(bit_val))
      else $error("skip if set wrong");
   a_skip_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      acc && req_i.op == OP_SKIP_IF_CLEAR |=> rsp_o.skip == !$past(bit_val))
      else $error("skip if clear wrong");

   // flags: zeros keep, ones clear, a hardware event always lands
   a_flag_zero_keeps: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      flag_clr == 8'h00 && flag_event_i == 8'h00 |=> $stable(flag_o))
      else $error("flag changed without event or clear");
   a_flag_one_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (flag_clr & ~flag_event_i) != 8'h00
      |=> (flag_o & $past(flag_clr & ~flag_event_i)) == 8'h00)
      else $error("written one did not clear flag");
   a_flag_event_wins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      flag_event_i != 8'h00 |=> (flag_o & $past(flag_event_i)) == $past(flag_event_i))
      else $error("flag event lost");

   // reset, and the nvm write that outlives it
   a_scratch_reset: assert property (@(posedge clk_i)
      !reset_n_i |=> scratch_q[0] == 8'h00 && scratch_q[1] == 8'h00)
      else $error("scratch not cleared by reset");
   a_reset_keeps_nvm: assert property (@(posedge clk_i) disable iff (!por_n_i)
      !reset_n_i && nvm_busy_o && nvm_busy |=> nvm_busy_o)
      else $error("system reset aborted nvm write");
   a_nvm_start: assert property (@(posedge clk_i) disable iff (!por_n_i)
      s_nvm_kick ##0 !nvm_busy |=> nvm_write_o && nvm_busy)
      else $error("nvm write did not start");
   a_nvm_no_restart: assert property (@(posedge clk_i) disable iff (!por_n_i)
      s_nvm_kick ##0 nvm_busy |=> !nvm_write_o)
      else $error("nvm write restarted while busy");
endmodule : io_space_scratch_regs
`default_nettype wire

//--- tb/cpu_core_model.sv
// cpu core model that issues one io access at a time
`default_nettype none
module cpu_core_model
   import io_space_pkg::*;
(
   input wire logic clk_i,
   output io_space_pkg::io_req_t req_o,
   input wire io_space_pkg::io_rsp_t rsp_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req_o = '0;

   ////////////////////////////////////////////////////////////////////////////////
   // request held until the taking edge, answer collected within a short bound
   task automatic access(input io_op_t op, input logic [7:0] a, input logic [2:0] b,
                         input logic [7:0] wd, output io_rsp_t rsp);
      int n;
      n = 0;
      @(posedge clk_i);
      req_o <= '{valid: 1'b1, op: op, addr: a, bit_sel: b, wdata: wd};
      @(posedge clk_i);
      req_o.valid <= 1'b0;
      // released lines move so a stale value never helps the design
      req_o.addr <= ~a;
      req_o.wdata <= ~wd;
      #1;
      while (rsp_i.done !== 1'b1 && n < 3) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      rsp = rsp_i;
   endtask : access

   // two requests on consecutive edges, valid held high between them
   task automatic access_pair(input io_op_t op0, input logic [7:0] a0, input logic [7:0] wd0,
                              input io_op_t op1, input logic [7:0] a1,
                              output io_rsp_t r0, output io_rsp_t r1);
      @(posedge clk_i);
      req_o <= '{valid: 1'b1, op: op0, addr: a0, bit_sel: 3'h0, wdata: wd0};
      @(posedge clk_i);
      req_o <= '{valid: 1'b1, op: op1, addr: a1, bit_sel: 3'h0, wdata: ~wd0};
      #1;
      r0 = rsp_i;
      @(posedge clk_i);
      req_o.valid <= 1'b0;
      req_o.addr <= ~a1;
      #1;
      r1 = rsp_i;
   endtask : access_pair
endmodule : cpu_core_model
`default_nettype wire

//--- tb/io_space_scratch_regs_test.sv
// self-checking bench for the io space decode and scratch registers
`default_nettype none
module io_space_scratch_regs_test
   import io_space_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned NVM_NS = 80;
   localparam int unsigned BUSY_CYC = (NVM_NS + 7) / 8;
   localparam logic [2:0] OK = 3'h4;
   localparam logic [2:0] BAD = 3'h6;
   logic clk_i;
   logic reset_n_i;
   logic por_n_i;
   logic [7:0] flag_event_i;
   io_req_t req_i;
   io_rsp_t rsp_o;
   io_rsp_t r;
   io_rsp_t r2;
   logic [7:0] flag_o;
   logic nvm_write_o;
   logic nvm_busy_o;
   logic [7:0] v;
   int miscompares = 0;
   int cmp_count = 0;
   int cnt;

   io_space_scratch_regs #(.NVM_WRITE_TIME_NS(NVM_NS)) u_dut (.clk_i(clk_i),
      .reset_n_i(reset_n_i), .por_n_i(por_n_i), .req_i(req_i), .flag_event_i(flag_event_i),
      .rsp_o(rsp_o), .flag_o(flag_o), .nvm_write_o(nvm_write_o), .nvm_busy_o(nvm_busy_o));
   cpu_core_model u_cpu (.clk_i(clk_i), .req_o(req_i), .rsp_i(rsp_o));

   ////////////////////////////////////////////////////////////////////////////////
   // compare, access and closing helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // flags are packed done, err, skip; read data only matters on reads
   task automatic acc(input io_op_t op, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] wd, input logic [7:0] rd, input logic [2:0] fl);
      u_cpu.access(op, a, b, wd, r);
      chk({5'h00, r.done, r.err, r.skip}, {5'h00, fl});
      if (op == OP_IN || op == OP_LOAD) chk(r.rdata, rd);
   endtask : acc

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // watchdog, far beyond the under 200 cycles the tests need
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n_i = 1'b0;
      por_n_i = 1'b0;
      flag_event_i = 8'h00;
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      por_n_i <= 1'b1;
      // each scratch register through both address views
      for (int i = 0; i < 3; i++) begin
         acc(OP_IN, 8'(8'h13 + i), 3'h0, 8'h00, 8'h00, OK);
         acc(OP_OUT, 8'(8'h13 + i), 3'h0, 8'(8'h5a ^ i), 8'h00, OK);
         acc(OP_LOAD, 8'(8'h33 + i), 3'h0, 8'h00, 8'(8'h5a ^ i), OK);
         acc(OP_STORE, 8'(8'h33 + i), 3'h0, 8'(8'ha5 ^ i), 8'h00, OK);
         acc(OP_IN, 8'(8'h13 + i), 3'h0, 8'h00, 8'(8'ha5 ^ i), OK);
      end
      acc(OP_SET_BIT, 8'h13, 3'h1, 8'h00, 8'h00, OK);
      acc(OP_CLEAR_BIT, 8'h13, 3'h0, 8'h00, 8'h00, OK);
      acc(OP_IN, 8'h13, 3'h0, 8'h00, 8'ha6, OK);
      v = 8'ha6;
      for (int b = 0; b < 8; b++) begin
         acc(OP_SKIP_IF_SET, 8'h13, 3'(b), 8'h00, 8'h00, {2'h2, v[b]});
         acc(OP_SKIP_IF_CLEAR, 8'h13, 3'(b), 8'h00, 8'h00, {2'h2, ~v[b]});
      end
      // back-to-back store and read: the write shows on the very next access
      u_cpu.access_pair(OP_STORE, 8'h33, 8'h3c, OP_IN, 8'h13, r, r2);
      chk({5'h00, r.done, r.err, r.skip}, {5'h00, OK});
      chk({5'h00, r2.done, r2.err, r2.skip}, {5'h00, OK});
      chk(r2.rdata, 8'h3c);
      // sticky flags: only a written one clears, bit ops stay on their bit
      @(posedge clk_i);
      flag_event_i <= 8'h0f;
      @(posedge clk_i);
      flag_event_i <= 8'h00;
      acc(OP_SET_BIT, 8'h16, 3'h2, 8'h00, 8'h00, OK);
      chk(flag_o, 8'h0b);
      acc(OP_CLEAR_BIT, 8'h16, 3'h0, 8'h00, 8'h00, OK);
      acc(OP_OUT, 8'h16, 3'h0, 8'h01, 8'h00, OK);
      acc(OP_IN, 8'h16, 3'h0, 8'h00, 8'h0a, OK);
      // addresses outside each instruction's window are refused
      acc(OP_IN, 8'h40, 3'h0, 8'h00, 8'h00, BAD);
      acc(OP_LOAD, 8'h1f, 3'h0, 8'h00, 8'h00, BAD);
      acc(OP_LOAD, 8'h60, 3'h0, 8'h00, 8'h00, BAD);
      acc(OP_SET_BIT, 8'h20, 3'h0, 8'h00, 8'h00, BAD);
      acc(OP_SKIP_IF_SET, 8'h20, 3'h0, 8'h00, 8'h00, BAD);
      // nvm write keeps its full length across a system reset
      acc(OP_STORE, 8'h37, 3'h0, 8'h01, 8'h00, OK);
      chk({7'h00, nvm_write_o}, 8'h01);
      acc(OP_IN, 8'h17, 3'h0, 8'h00, 8'h02, OK);
      // a second start while busy must be dropped, not restart the timer
      acc(OP_OUT, 8'h17, 3'h0, 8'h01, 8'h00, OK);
      chk({7'h00, nvm_write_o}, 8'h00);
      cnt = 0;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk_i);
         reset_n_i <= (k < 2 || k > 3);
         #1;
         if (nvm_busy_o === 1'b1) cnt++;
      end
      // four busy cycles already went by during the three accesses above
      chk(8'(cnt), 8'(BUSY_CYC - 4));
      acc(OP_IN, 8'h17, 3'h0, 8'h00, 8'h00, OK);
      acc(OP_IN, 8'h16, 3'h0, 8'h00, 8'h00, OK);
      acc(OP_IN, 8'h13, 3'h0, 8'h00, 8'h00, OK);
      end_sim();
   end
endmodule : io_space_scratch_regs_test
`default_nettype wire
